// ===== logic/oovp_pkg.sv
// Purpose: Constants for the output overvoltage protection block
// Assumes: Decoded host transactions arrive on the clk domain
// Notes: Shared by the top module and the per-channel module
package oovp_pkg;
	localparam logic [7:0] CMD_PAGE = 8'h00;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_OUTPUT_CEILING = 8'h24;
	localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
	localparam logic [7:0] CMD_OV_RESPONSE = 8'h41;
	localparam logic [7:0] CMD_DAC_STEP_SELECT = 8'hD0;
	localparam logic [7:0] PAGE_A = 8'h00;
	localparam logic [7:0] PAGE_B = 8'h01;
	localparam logic [7:0] PAGE_ALL = 8'hFF;
	localparam logic [7:0] OV_RESPONSE_CODE = 8'h80;
	localparam logic [7:0] OV_LIMIT_FORCED = 8'hFF;
	localparam logic [7:0] OV_LIMIT_OFFSET = 8'h10;
	localparam logic [7:0] CEILING_RESET = 8'hC0;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	// Bit positions inside the PMBus status registers
	localparam int STATUS_BYTE_OV_BIT = 5;
	localparam int STATUS_WORD_VOUT_BIT = 15;
	localparam int STATUS_VOUT_OV_BIT = 7;
endpackage

// ===== logic/oovp_chan_if.sv
// Purpose: Carrier between the top module and one protection channel
// Assumes: Single clock domain
// Notes: One instance per channel
`timescale 1ns/1ps
`default_nettype none
interface oovp_chan_if;
	logic [7:0] ceiling;
	logic step5mv;
	logic [7:0] senseCode;
	logic [7:0] reqCode;
	logic enableLevel;
	logic [7:0] limit;
	logic [7:0] cmdCode;
	logic fault;
	logic latched;
	modport top (output ceiling, step5mv, senseCode, reqCode, enableLevel,
		input limit, cmdCode, fault, latched);
	modport chan (input ceiling, step5mv, senseCode, reqCode, enableLevel,
		output limit, cmdCode, fault, latched);
endinterface
`default_nettype wire

// ===== logic/oovp_channel.sv
// Purpose: Limit derivation, fault detection, latch-off and clamp for one channel
// Assumes: Enable level already synchronised
// Notes: Fault is a one-cycle pulse on the cycle the latch sets
`timescale 1ns/1ps
`default_nettype none
module oovp_channel (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Channel carrier
	oovp_chan_if.chan ch
);
	logic [8:0] rawLimit;
	logic [7:0] next_limit;
	logic enablePrev;

	assign rawLimit = {1'b0, ch.ceiling} + {1'b0, oovp_pkg::OV_LIMIT_OFFSET};

	always_comb begin
		if (ch.step5mv) begin
			next_limit = oovp_pkg::OV_LIMIT_FORCED;
		end else if (rawLimit[8]) begin
			next_limit = oovp_pkg::OV_LIMIT_FORCED;
		end else begin
			next_limit = rawLimit[7:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ch.limit <= oovp_pkg::OV_LIMIT_FORCED;
		end else begin
			ch.limit <= next_limit;
		end
	end

	// Fault only while converting; once latched the pulse does not repeat
	always_ff @(posedge clk) begin
		if (rst) begin
			ch.latched <= 1'b0;
			ch.fault <= 1'b0;
			enablePrev <= 1'b0;
		end else begin
			enablePrev <= ch.enableLevel;
			ch.fault <= 1'b0;
			if (enablePrev && !ch.enableLevel) begin
				ch.latched <= 1'b0;
			end else if (!ch.latched && ch.enableLevel && ch.senseCode > ch.limit) begin
				ch.latched <= 1'b1;
				ch.fault <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			ch.cmdCode <= 8'h00;
		end else if (ch.reqCode > ch.ceiling) begin
			ch.cmdCode <= ch.ceiling;
		end else begin
			ch.cmdCode <= ch.reqCode;
		end
	end
endmodule // oovp_channel
`default_nettype wire

// ===== logic/oovp_top.sv
// Purpose: Output overvoltage protection for two channels with paged registers
// Assumes: Host transactions arrive decoded, one command per strobe, on clk
// Notes: Bias supply cycling is represented by rst
`timescale 1ns/1ps
`default_nettype none
module oovp_top (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Decoded host transaction
	input wire logic txnValid,
	input wire logic txnWrite,
	input wire logic [7:0] txnCmd,
	input wire logic [15:0] txnData,
	output logic rdValid,
	output logic [15:0] rdData,
	// Channel pins and controls
	input wire logic [1:0] channelEnablePins,
	input wire logic [1:0] opOnBit,
	input wire logic [1:0] useOpOnBit,
	input wire logic ovAlertMask,
	input wire logic [15:0] senseCodeA,
	input wire logic [15:0] senseCodeB,
	input wire logic [7:0] reqCodeA,
	input wire logic [7:0] reqCodeB,
	// Channel outputs
	output logic [1:0] convertEn,
	output logic [7:0] cmdCodeA,
	output logic [7:0] cmdCodeB,
	// Status and alert
	output logic [7:0] statusByte,
	output logic [15:0] statusWord,
	output logic [7:0] statusVoutA,
	output logic [7:0] statusVoutB,
	output logic hostAlert
);
	// ************************************************************
	// Pin synchronisers and channel instances
	// ************************************************************
	logic [1:0] enMeta;
	logic [1:0] enSync;
	logic [7:0] page;
	logic [7:0] ceilingA;
	logic [7:0] ceilingB;
	logic step5mv;
	logic [1:0] faultPulse;
	logic [1:0] latched;
	oovp_chan_if chA ();
	oovp_chan_if chB ();

	always_ff @(posedge clk) begin
		if (rst) begin
			enMeta <= 2'h0;
			enSync <= 2'h0;
		end else begin
			enMeta <= channelEnablePins;
			enSync <= enMeta;
		end
	end

	assign chA.ceiling = ceilingA;
	assign chB.ceiling = ceilingB;
	assign chA.step5mv = step5mv;
	assign chB.step5mv = step5mv;
	// Sense code is an 8-bit VID code held in the low byte
	assign chA.senseCode = senseCodeA[7:0];
	assign chB.senseCode = senseCodeB[7:0];
	assign chA.reqCode = reqCodeA;
	assign chB.reqCode = reqCodeB;
	// Toggling whichever source the on/off setting selects clears the latch
	assign chA.enableLevel = useOpOnBit[0] ? (enSync[0] && opOnBit[0]) : enSync[0];
	assign chB.enableLevel = useOpOnBit[1] ? (enSync[1] && opOnBit[1]) : enSync[1];
	assign faultPulse = {chB.fault, chA.fault};
	assign latched = {chB.latched, chA.latched};

	oovp_channel uChanA (
		.clk(clk),
		.rst(rst),
		.ch(chA)
	);
	oovp_channel uChanB (
		.clk(clk),
		.rst(rst),
		.ch(chB)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			convertEn <= 2'h0;
			cmdCodeA <= 8'h00;
			cmdCodeB <= 8'h00;
		end else begin
			convertEn <= {chB.enableLevel && !chB.latched && !faultPulse[1],
				chA.enableLevel && !chA.latched && !faultPulse[0]};
			cmdCodeA <= chA.cmdCode;
			cmdCodeB <= chB.cmdCode;
		end
	end

	// ************************************************************
	// Writable registers
	// ************************************************************
	logic wrEn;
	logic selA;
	logic selB;
	assign wrEn = txnValid && txnWrite;
	assign selA = (page == oovp_pkg::PAGE_A) || (page == oovp_pkg::PAGE_ALL);
	assign selB = (page == oovp_pkg::PAGE_B) || (page == oovp_pkg::PAGE_ALL);

	// Limit and response offsets have no write path at all
	always_ff @(posedge clk) begin
		if (rst) begin
			page <= oovp_pkg::PAGE_RESET;
			ceilingA <= oovp_pkg::CEILING_RESET;
			ceilingB <= oovp_pkg::CEILING_RESET;
			step5mv <= 1'b0;
		end else if (wrEn) begin
			case (txnCmd)
				oovp_pkg::CMD_PAGE: begin
					page <= txnData[7:0];
				end
				oovp_pkg::CMD_OUTPUT_CEILING: begin
					if (selA) begin
						ceilingA <= txnData[7:0];
					end
					if (selB) begin
						ceilingB <= txnData[7:0];
					end
				end
				oovp_pkg::CMD_DAC_STEP_SELECT: begin
					step5mv <= txnData[0];
				end
				default: begin
				end
			endcase
		end
	end

	// ************************************************************
	// Read path
	// ************************************************************
	logic [15:0] next_rdData;
	always_comb begin
		next_rdData = 16'h0000;
		case (txnCmd)
			oovp_pkg::CMD_PAGE: next_rdData = {8'h00, page};
			oovp_pkg::CMD_OUTPUT_CEILING: begin
				next_rdData = {8'h00, selA ? ceilingA : (selB ? ceilingB : 8'h00)};
			end
			oovp_pkg::CMD_OV_LIMIT: begin
				next_rdData = {8'h00, selA ? chA.limit : (selB ? chB.limit : 8'h00)};
			end
			oovp_pkg::CMD_OV_RESPONSE: next_rdData = {8'h00, oovp_pkg::OV_RESPONSE_CODE};
			oovp_pkg::CMD_DAC_STEP_SELECT: next_rdData = {15'h0000, step5mv};
			default: next_rdData = 16'h0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdValid <= 1'b0;
			rdData <= 16'h0000;
		end else begin
			rdValid <= txnValid && !txnWrite;
			rdData <= (txnValid && !txnWrite) ? next_rdData : 16'h0000;
		end
	end

	// ************************************************************
	// Status flags and alert
	// ************************************************************
	logic clearReq;
	logic [1:0] ovFlag;
	logic [1:0] next_ovFlag;
	logic anyOv;
	logic [7:0] next_statusByte;
	logic [15:0] next_statusWord;
	logic [7:0] next_statusVoutA;
	logic [7:0] next_statusVoutB;
	assign clearReq = wrEn && (txnCmd == oovp_pkg::CMD_CLEAR_FAULTS);
	// A fault in the clearing cycle survives the clear
	assign next_ovFlag = (clearReq ? 2'h0 : ovFlag) | faultPulse;
	assign anyOv = |next_ovFlag;

	always_ff @(posedge clk) begin
		if (rst) begin
			ovFlag <= 2'h0;
		end else begin
			ovFlag <= next_ovFlag;
		end
	end

	// Only the overvoltage bits are owned here; other status sources sit outside
	always_comb begin
		next_statusByte = 8'h00;
		next_statusWord = 16'h0000;
		next_statusVoutA = 8'h00;
		next_statusVoutB = 8'h00;
		next_statusByte[oovp_pkg::STATUS_BYTE_OV_BIT] = anyOv;
		next_statusWord[oovp_pkg::STATUS_BYTE_OV_BIT] = anyOv;
		next_statusWord[oovp_pkg::STATUS_WORD_VOUT_BIT] = anyOv;
		next_statusVoutA[oovp_pkg::STATUS_VOUT_OV_BIT] = next_ovFlag[0];
		next_statusVoutB[oovp_pkg::STATUS_VOUT_OV_BIT] = next_ovFlag[1];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			statusByte <= 8'h00;
			statusWord <= 16'h0000;
			statusVoutA <= 8'h00;
			statusVoutB <= 8'h00;
		end else begin
			statusByte <= next_statusByte;
			statusWord <= next_statusWord;
			statusVoutA <= next_statusVoutA;
			statusVoutB <= next_statusVoutB;
		end
	end

	// Alert follows the flags, so it drops with the clear that empties them
	always_ff @(posedge clk) begin
		if (rst) begin
			hostAlert <= 1'b0;
		end else begin
			hostAlert <= anyOv && !ovAlertMask;
		end
	end
endmodule // oovp_top
`default_nettype wire

// ===== verif/oovp_host_model.sv
// Purpose: Host stand-in issuing decoded commands
// Assumes: Drives at falling edges
// Notes: Released lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module oovp_host_model (
	// Clock
	input wire logic clk,
	// Command
	output logic txnValid,
	output logic txnWrite,
	output logic [7:0] txnCmd,
	output logic [15:0] txnData,
	// Answer
	input wire logic rdValid,
	input wire logic [15:0] rdData
);
	initial {txnValid, txnWrite, txnCmd, txnData} = '0;
	// Whole word each time; byte commands carry their byte low
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q);
		q = 16'hXXXX;
		@(negedge clk);
		{txnValid, txnWrite, txnCmd, txnData} = {1'b1, w, c, d};
		@(negedge clk);
		{txnValid, txnCmd, txnData} = {1'b0, ~c, ~d};
		if (!w && rdValid === 1'b1) q = rdData;
	endtask
endmodule // oovp_host_model
`default_nettype wire

// ===== verif/oovp_assertions.sv
// Purpose: Port checks of overvoltage protection
// Assumes: One clock, synchronous reset
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module oovp_assertions (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Host
	input wire logic txnValid,
	input wire logic txnWrite,
	input wire logic [7:0] txnCmd,
	input wire logic rdValid,
	input wire logic [15:0] rdData,
	// Channels
	input wire logic [1:0] channelEnablePins,
	input wire logic ovAlertMask,
	input wire logic [1:0] convertEn,
	input wire logic [7:0] statusByte,
	input wire logic [15:0] statusWord,
	input wire logic [7:0] statusVoutA,
	input wire logic hostAlert
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_read_answer: assert property (txnValid && !txnWrite |=> rdValid)
		else $error("read not answered");
	a_write_silent: assert property (txnValid && txnWrite |=> !rdValid)
		else $error("write answered");
	a_resp_fixed: assert property (rdValid && $past(txnCmd) == 8'h41 |-> rdData == 16'h0080)
		else $error("response code wrong");
	a_limit_high: assert property (rdValid && $past(txnCmd) == 8'h40 |-> rdData[15:8] == 8'h00)
		else $error("limit upper byte set");
	a_alert_masked: assert property ($past(ovAlertMask) |-> !hostAlert)
		else $error("masked alert raised");
	a_fault_stops: assert property ($rose(statusVoutA[7]) |-> !convertEn[0])
		else $error("faulted channel converting");
	a_status_mirror: assert property (statusByte[5] |-> statusWord[15] && statusWord[5])
		else $error("status word flags missing");
	a_enable_gate: assert property ($rose(convertEn[0]) |-> $past(channelEnablePins[0], 3))
		else $error("converting without enable");
endmodule // oovp_assertions
bind oovp_top oovp_assertions chk (.clk, .rst, .txnValid, .txnWrite, .txnCmd, .rdValid,
	.rdData, .channelEnablePins, .ovAlertMask, .convertEn, .statusByte, .statusWord,
	.statusVoutA, .hostAlert);
`default_nettype wire

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for overvoltage protection
// Assumes: Host model sends commands
// Notes: Table first, then fault, latch and reset cases
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
	$display("Error %s exp %h got %h", n, e, a); end end
module tb_top;
	typedef struct {logic w; logic [7:0] c; logic [15:0] d; logic [15:0] e;} oovp_row_t;
	logic clk, rst, txnValid, txnWrite, rdValid, ovAlertMask, hostAlert;
	logic [7:0] txnCmd, reqCodeA, reqCodeB, cmdCodeA, cmdCodeB;
	logic [7:0] statusByte, statusVoutA, statusVoutB;
	logic [15:0] txnData, rdData, senseCodeA, senseCodeB, statusWord, q;
	logic [1:0] channelEnablePins, opOnBit, useOpOnBit, convertEn;
	int miscompares, comparisons;
	// Limit is ceiling plus offset, saturating
	function automatic logic [15:0] lim(input logic [7:0] c);
		return (c > 8'hFF - oovp_pkg::OV_LIMIT_OFFSET) ? 16'h00FF :
			{8'h00, c + oovp_pkg::OV_LIMIT_OFFSET};
	endfunction
	oovp_row_t rows [$] = '{
		'{'0, 8'h41, '0, 16'h0080}, '{'1, 8'h41, 16'h5555, '0}, '{'0, 8'h41, '0, 16'h0080},
		'{'0, 8'h40, '0, lim(8'hC0)}, '{'1, 8'h40, 16'h1234, '0}, '{'0, 8'h40, '0, lim(8'hC0)},
		'{'1, 8'h24, 16'h0020, '0}, '{'0, 8'h40, '0, lim(8'h20)}, '{'1, 8'h00, 16'h0001, '0},
		'{'0, 8'h40, '0, lim(8'hC0)}, '{'0, 8'h41, '0, 16'h0080}, '{'1, 8'h24, 16'h00F8, '0},
		'{'0, 8'h40, '0, 16'h00FF}, '{'1, 8'h00, 16'h00FF, '0}, '{'1, 8'h24, 16'h0050, '0},
		'{'0, 8'h40, '0, lim(8'h50)}, '{'1, 8'h00, 16'h0001, '0}, '{'0, 8'h40, '0, lim(8'h50)},
		'{'1, 8'hD0, 16'h0001, '0}, '{'0, 8'h40, '0, 16'h00FF}, '{'1, 8'hD0, '0, '0},
		'{'1, 8'h00, 16'h0002, '0}, '{'0, 8'h40, '0, '0}, '{'1, 8'h00, '0, '0}};
	oovp_host_model host (.clk, .txnValid, .txnWrite, .txnCmd, .txnData, .rdValid, .rdData);
	oovp_top DUT (.clk, .rst, .txnValid, .txnWrite, .txnCmd, .txnData, .rdValid, .rdData,
		.channelEnablePins, .opOnBit, .useOpOnBit, .ovAlertMask, .senseCodeA, .senseCodeB,
		.reqCodeA, .reqCodeB, .convertEn, .cmdCodeA, .cmdCodeB, .statusByte, .statusWord,
		.statusVoutA, .statusVoutB, .hostAlert);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic final_report;
		if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		final_report;
	end
	initial begin
		rst = 1'b1;
		{channelEnablePins, opOnBit, useOpOnBit, ovAlertMask} = '0;
		{senseCodeA, senseCodeB, reqCodeA, reqCodeB} = '0;
		idle(20);
		`CHK("statusWord", 16'h0000, statusWord)
		rst = 1'b0;
		foreach (rows[i]) begin
			host.xfer(rows[i].w, rows[i].c, rows[i].d, q);
			if (!rows[i].w) `CHK("rdData", rows[i].e, q)
		end
		reqCodeA = 8'h70;
		reqCodeB = 8'h30;
		channelEnablePins = 2'b11;
		idle(6);
		`CHK("convertEn", 2'b11, convertEn)
		`CHK("cmdCodeA", 8'h50, cmdCodeA)
		`CHK("cmdCodeB", 8'h30, cmdCodeB)
		senseCodeA = 16'h0061;
		idle(3);
		`CHK("convertEn", 2'b10, convertEn)
		`CHK("statusVoutA", 8'h80, statusVoutA)
		`CHK("statusVoutB", 8'h00, statusVoutB)
		`CHK("statusByte", 1'b1, statusByte[5])
		`CHK("statusWord", 16'h8020, statusWord)
		`CHK("hostAlert", 1'b1, hostAlert)
		senseCodeA = '0;
		idle(3);
		`CHK("convertEn", 2'b10, convertEn)
		channelEnablePins = 2'b10;
		idle(4);
		channelEnablePins = 2'b11;
		idle(5);
		`CHK("convertEn", 2'b11, convertEn)
		host.xfer('1, 8'h03, '0, q);
		idle(1);
		`CHK("hostAlert", 1'b0, hostAlert)
		{ovAlertMask, useOpOnBit, opOnBit} = 5'h1A;
		senseCodeB = 16'h0061;
		idle(3);
		`CHK("hostAlert", 1'b0, hostAlert)
		`CHK("convertEn", 2'b01, convertEn)
		`CHK("statusVoutB", 8'h80, statusVoutB)
		opOnBit = 2'b00;
		senseCodeB = '0;
		idle(2);
		opOnBit = 2'b10;
		idle(3);
		`CHK("convertEn", 2'b11, convertEn)
		rst = 1'b1;
		idle(3);
		`CHK("statusVoutB", 8'h00, statusVoutB)
		final_report;
	end
endmodule // tb_top
`default_nettype wire
